// [thermal_overload_pkg.sv]
// constants, types and register map of the thermal overload output stage
`default_nettype none
package thermal_overload_pkg;
  // clock and processing cycle timing
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned STEP_TIME_NS = 5_000_000; // one delay step, 5 ms
  localparam int unsigned CYCLE_CLKS = STEP_TIME_NS / CLK_PERIOD_NS;

  // register byte offsets
  localparam logic [7:0] ADDR_ENABLE = 8'h00;
  localparam logic [7:0] ADDR_ALARM1_LVL = 8'h04;
  localparam logic [7:0] ADDR_ALARM2_LVL = 8'h08;
  localparam logic [7:0] ADDR_INHIBIT_LVL = 8'h0c;
  localparam logic [7:0] ADDR_TRIP_LVL = 8'h10;
  localparam logic [7:0] ADDR_TRIP_DELAY = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;

  // enable register bit positions
  localparam int EN_ALARM1 = 0;
  localparam int EN_ALARM2 = 1;
  localparam int EN_INHIBIT = 2;
  localparam int EN_TRIP = 3;

  // status register field positions
  localparam int ST_OUTS = 0;   // [3:0] alarm1, alarm2, inhibit, trip
  localparam int ST_START = 4;
  localparam int ST_BLOCKED = 5;
  localparam int ST_COND = 6;   // [8:6]
  localparam int ST_LOAD = 9;   // [10:9]
  localparam int ST_FAULTS = 11; // [14:11] sf, ambient, nominal, amb k

  // thresholds in 0.1 percent units, delay in 5 ms steps
  localparam logic [10:0] ALARM1_LVL_RST = 11'h190; // 40.0 %
  localparam logic [10:0] ALARM2_LVL_RST = 11'h190; // 40.0 %
  localparam logic [10:0] INHIBIT_LVL_RST = 11'h320; // 80.0 %
  localparam logic [10:0] TRIP_LVL_RST = 11'h3e8; // 100.0 %
  localparam logic [19:0] TRIP_DELAY_RST = 20'h00000; // 0.000 s
  localparam logic [3:0] ENABLE_RST = 4'h0;

  // current in 0.1 percent of nominal
  localparam logic [15:0] LIGHT_LOAD_LIMIT = 16'h000a; // 1 %
  localparam logic [15:0] HIGH_LOAD_LIMIT = 16'h07d0; // 2 x nominal

  // substitute factor 1.0 in 8.8 fixed point
  localparam logic [15:0] FACTOR_ONE = 16'h0100;

  // operating condition, gray coded along rising severity
  typedef enum logic [2:0] {
    COND_NORMAL = 3'h0,
    COND_ALARM1 = 3'h1,
    COND_ALARM2 = 3'h3,
    COND_INHIBIT = 3'h2,
    COND_TRIP = 3'h6,
    COND_BLOCKED = 3'h7
  } cond_e;

  // load classification
  typedef enum logic [1:0] {
    LOAD_LIGHT = 2'h0,
    LOAD_NORMAL = 2'h1,
    LOAD_OVER = 2'h3,
    LOAD_HIGH = 2'h2
  } load_e;

  // setting inputs from the thermal image side
  typedef struct packed {
    logic [15:0] service_factor;
    logic sf_invalid;
    logic [15:0] ambient_k;
    logic amb_invalid;
    logic [15:0] nominal_calc;
    logic nom_invalid;
    logic ambk_inconsistent;
  } settings_s;

  // used factors after substitution
  typedef struct packed {
    logic [15:0] service_factor;
    logic [15:0] ambient_k;
    logic [15:0] nominal_calc;
  } factors_s;

  // whole state of the stage
  typedef struct packed {
    logic [15:0] tick_cnt;
    logic cycle;
    logic blk_sampled;
    logic [3:0] enable;
    logic [10:0] alarm1_lvl;
    logic [10:0] alarm2_lvl;
    logic [10:0] inhibit_lvl;
    logic [10:0] trip_lvl;
    logic [19:0] trip_delay;
    logic [19:0] delay_cnt;
    logic alarm1;
    logic alarm2;
    logic inhibit;
    logic trip;
    logic start;
    logic blocked;
    cond_e cond;
    load_e load;
    logic [3:0] faults;
    factors_s used;
    logic [31:0] rdata;
  } state_s;
endpackage : thermal_overload_pkg
`default_nettype wire

// [thermal_overload_stage.sv]
// output, blocking and status stage of the line thermal overload function
// Functional notes
// R1: outputs come only from the supplied thermal capacity value.
// R2: alarm 1 has an enable, off after reset; off means never driven.
// R3: alarm 2 has an enable, off after reset; off means never driven.
// R4: four thresholds in 0.1 % steps, defaults 40, 40, 80, 100 %.
// R5: trip delayed by settable time up to 3600 s, 5 ms steps.
// R6: settings may change at any time without restarting the function.
// R7: blocking input sampled once per processing cycle, held for it.
// R8: pick-up while not blocked raises start and runs the delay.
// R9: pick-up while blocked raises blocked and nothing more.
// R10: blocking after start clears start and releases as on reset.
// R11: blocking must arrive at least 5 ms before the delay expires.
// R12: condition code reported; no outputs driven while it is normal (here start can still be set while it is normal).
// R13: load classified as light, normal, overloading or high overload.
// R14: invalid service factor replaced by 1.0, fault shown while present.
// R15: invalid ambient settings give 1.0, fault shown while present.
// R16: invalid nominal current setting gives 1.0, fault while present.
// R17: inconsistent ambient k flagged as its own fault while present.
// R18: inhibit and trip have enables, off after reset, never assert off.
// R19: enabled output asserts at or above threshold, drops below it.
// R20: condition reports most severe: blocked, trip, inhibit, alarms.
`default_nettype none
module thermal_overload_stage
  import thermal_overload_pkg::*;
#(
  parameter int unsigned P_CYCLE_CLKS = CYCLE_CLKS
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic [10:0] i_capacity,
  input wire logic [15:0] i_current,
  input wire logic [15:0] i_pickup_current,
  input wire logic i_block,
  input wire settings_s i_settings,
  output logic o_alarm1,
  output logic o_alarm2,
  output logic o_inhibit,
  output logic o_trip,
  output logic o_start,
  output logic o_blocked,
  output cond_e o_condition,
  output load_e o_load,
  output logic [3:0] o_faults,
  output factors_s o_used,
  output logic o_cycle
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release through two flip-flops
  logic [1:0] rst_sync_reg;
  logic rst_n;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_reg[1];

  ////////////////////////////////////////////////////////////////////////////
  // state and next state
  state_s st_reg;
  state_s st_next;
  logic tick;
  logic blk_now;
  logic pickup;
  logic start_next;

  // processing cycle boundary
  assign tick = (st_reg.tick_cnt == 16'(P_CYCLE_CLKS - 1));
  // blocking as seen during this cycle, fresh at its start
  assign blk_now = tick ? i_block : st_reg.blk_sampled; // R7
  assign pickup = st_reg.enable[EN_TRIP] &&
                  (i_capacity >= st_reg.trip_lvl); // R1 R19

  always_comb begin
    st_next = st_reg;
    start_next = st_reg.start;
    st_next.rdata = 32'h0;
    st_next.tick_cnt = tick ? 16'h0 : st_reg.tick_cnt + 16'h1;
    st_next.cycle = tick; // first clock of the next cycle

    // register writes, taken live without restart
    if (i_wr) begin // R6
      case (i_addr)
        ADDR_ENABLE: st_next.enable = i_wdata[3:0];
        ADDR_ALARM1_LVL: st_next.alarm1_lvl = i_wdata[10:0]; // R4
        ADDR_ALARM2_LVL: st_next.alarm2_lvl = i_wdata[10:0]; // R4
        ADDR_INHIBIT_LVL: st_next.inhibit_lvl = i_wdata[10:0]; // R4
        ADDR_TRIP_LVL: st_next.trip_lvl = i_wdata[10:0]; // R4
        ADDR_TRIP_DELAY: st_next.trip_delay = i_wdata[19:0]; // R5
        default: st_next.enable = st_reg.enable;
      endcase
    end

    // register reads, data in the following cycle only
    if (i_rd) begin
      case (i_addr)
        ADDR_ENABLE: st_next.rdata = {28'h0, st_reg.enable};
        ADDR_ALARM1_LVL: st_next.rdata = {21'h0, st_reg.alarm1_lvl};
        ADDR_ALARM2_LVL: st_next.rdata = {21'h0, st_reg.alarm2_lvl};
        ADDR_INHIBIT_LVL: st_next.rdata = {21'h0, st_reg.inhibit_lvl};
        ADDR_TRIP_LVL: st_next.rdata = {21'h0, st_reg.trip_lvl};
        ADDR_TRIP_DELAY: st_next.rdata = {12'h0, st_reg.trip_delay};
        ADDR_STATUS: begin
          st_next.rdata[ST_OUTS +: 4] = {st_reg.trip, st_reg.inhibit,
                                         st_reg.alarm2, st_reg.alarm1};
          st_next.rdata[ST_START] = st_reg.start;
          st_next.rdata[ST_BLOCKED] = st_reg.blocked;
          st_next.rdata[ST_COND +: 3] = st_reg.cond;
          st_next.rdata[ST_LOAD +: 2] = st_reg.load;
          st_next.rdata[ST_FAULTS +: 4] = st_reg.faults;
        end
        default: st_next.rdata = 32'h0;
      endcase
    end

    // once per processing cycle: sample blocking, evaluate outputs
    if (tick) begin
      st_next.blk_sampled = i_block; // R7
      st_next.alarm1 = st_reg.enable[EN_ALARM1] &&
                       (i_capacity >= st_reg.alarm1_lvl); // R2 R19
      st_next.alarm2 = st_reg.enable[EN_ALARM2] &&
                       (i_capacity >= st_reg.alarm2_lvl); // R3 R19
      st_next.inhibit = st_reg.enable[EN_INHIBIT] &&
                        (i_capacity >= st_reg.inhibit_lvl); // R18 R19
      // start and blocked path
      start_next = pickup && !blk_now; // R8 R9 R10
      st_next.start = start_next;
      st_next.blocked = pickup && blk_now; // R9
      // added trip delay, restarted on release or blocking
      if (!start_next) begin
        st_next.delay_cnt = 20'h0; // R10
        st_next.trip = 1'b0; // R18
      end else if (st_reg.delay_cnt >= st_reg.trip_delay) begin
        st_next.trip = 1'b1; // R5
      end else begin
        st_next.delay_cnt = st_reg.delay_cnt + 20'h1; // R5
        st_next.trip = 1'b0;
      end
    end

    // condition code from the values being registered
    if (st_next.blocked) begin // R20
      st_next.cond = COND_BLOCKED;
    end else if (st_next.trip) begin
      st_next.cond = COND_TRIP;
    end else if (st_next.inhibit) begin
      st_next.cond = COND_INHIBIT;
    end else if (st_next.alarm2) begin
      st_next.cond = COND_ALARM2;
    end else if (st_next.alarm1) begin
      st_next.cond = COND_ALARM1;
    end else begin
      st_next.cond = COND_NORMAL; // R12
    end

    // load classification from measured current
    if (i_current < LIGHT_LOAD_LIMIT) begin // R13
      st_next.load = LOAD_LIGHT;
    end else if (i_current <= i_pickup_current) begin
      st_next.load = LOAD_NORMAL;
    end else if (i_current < HIGH_LOAD_LIMIT) begin
      st_next.load = LOAD_OVER;
    end else begin
      st_next.load = LOAD_HIGH;
    end

    // setting faults shown only while present, with substitutes
    st_next.faults = {i_settings.ambk_inconsistent, i_settings.nom_invalid,
                      i_settings.amb_invalid, i_settings.sf_invalid}; // R17
    st_next.used.service_factor = i_settings.sf_invalid ? FACTOR_ONE :
                                  i_settings.service_factor; // R14
    st_next.used.ambient_k = i_settings.amb_invalid ? FACTOR_ONE :
                             i_settings.ambient_k; // R15
    st_next.used.nominal_calc = i_settings.nom_invalid ? FACTOR_ONE :
                                i_settings.nominal_calc; // R16
  end

  // state register
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '{tick_cnt: 16'h0, cycle: 1'b1, blk_sampled: 1'b0,
                  enable: ENABLE_RST,
                  alarm1_lvl: ALARM1_LVL_RST, alarm2_lvl: ALARM2_LVL_RST,
                  inhibit_lvl: INHIBIT_LVL_RST, trip_lvl: TRIP_LVL_RST,
                  trip_delay: TRIP_DELAY_RST, delay_cnt: 20'h0,
                  alarm1: 1'b0, alarm2: 1'b0, inhibit: 1'b0, trip: 1'b0,
                  start: 1'b0, blocked: 1'b0, cond: COND_NORMAL,
                  load: LOAD_LIGHT, faults: 4'h0,
                  used: '{FACTOR_ONE, FACTOR_ONE, FACTOR_ONE},
                  rdata: 32'h0};
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from the state register
  assign o_rdata = st_reg.rdata;
  assign o_alarm1 = st_reg.alarm1;
  assign o_alarm2 = st_reg.alarm2;
  assign o_inhibit = st_reg.inhibit;
  assign o_trip = st_reg.trip;
  assign o_start = st_reg.start;
  assign o_blocked = st_reg.blocked;
  assign o_condition = st_reg.cond;
  assign o_load = st_reg.load;
  assign o_faults = st_reg.faults;
  assign o_used = st_reg.used;
  assign o_cycle = st_reg.cycle;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  // output levels against thresholds and enables
  a_alarm1_level: assert property (@(posedge i_clk) // R2
    disable iff (!rst_n) tick |=> (o_alarm1 ==
      ($past(st_reg.enable[EN_ALARM1]) &&
       $past(i_capacity) >= $past(st_reg.alarm1_lvl))))
    else $error("alarm 1 does not follow threshold");
  a_alarm2_level: assert property (@(posedge i_clk) // R3
    disable iff (!rst_n) tick |=> (o_alarm2 ==
      ($past(st_reg.enable[EN_ALARM2]) &&
       $past(i_capacity) >= $past(st_reg.alarm2_lvl))))
    else $error("alarm 2 does not follow threshold");
  a_inhibit_level: assert property (@(posedge i_clk) // R18 R19
    disable iff (!rst_n) tick |=> (o_inhibit ==
      ($past(st_reg.enable[EN_INHIBIT]) &&
       $past(i_capacity) >= $past(st_reg.inhibit_lvl))))
    else $error("inhibit does not follow threshold");
  a_inhibit_gate: assert property (@(posedge i_clk) // R18
    disable iff (!rst_n) !st_reg.enable[EN_INHIBIT] && tick |=> !o_inhibit)
    else $error("inhibit asserted while disabled");
  a_trip_gate: assert property (@(posedge i_clk) // R18
    disable iff (!rst_n) !st_reg.enable[EN_TRIP] && tick |=>
      !o_trip && !o_start)
    else $error("trip path active while disabled");

  // start, blocking and trip delay
  a_trip_no_start: assert property (@(posedge i_clk) // R8
    disable iff (!rst_n) o_trip |-> o_start && !o_blocked)
    else $error("trip without start");
  a_pickup_start: assert property (@(posedge i_clk) // R8
    disable iff (!rst_n) tick && pickup && !i_block |=>
      o_start && !o_blocked)
    else $error("no start on unblocked pick-up");
  a_blocked_pickup: assert property (@(posedge i_clk) // R9
    disable iff (!rst_n) tick && pickup && i_block |=>
      o_blocked && !o_start && !o_trip)
    else $error("blocked pick-up processed further");
  a_block_release: assert property (@(posedge i_clk) // R10
    disable iff (!rst_n) o_start && tick && i_block |=>
      !o_start && st_reg.delay_cnt == 20'h0)
    else $error("start not released on blocking");
  a_pickup_loss: assert property (@(posedge i_clk) // R10 R19
    disable iff (!rst_n) tick && !pickup |=>
      !o_start && !o_trip && !o_blocked && st_reg.delay_cnt == 20'h0)
    else $error("start kept after pick-up loss");
  a_zero_delay_trip: assert property (@(posedge i_clk) // R5
    disable iff (!rst_n) tick && pickup && !i_block &&
      st_reg.trip_delay == 20'h0 |=> o_trip)
    else $error("trip delayed with zero delay");
  a_delay_wait: assert property (@(posedge i_clk) // R5
    disable iff (!rst_n) tick && pickup && !i_block &&
      st_reg.delay_cnt < st_reg.trip_delay |=> !o_trip)
    else $error("trip ahead of its delay");
  a_delay_done: assert property (@(posedge i_clk) // R5
    disable iff (!rst_n) tick && pickup && !i_block &&
      st_reg.delay_cnt >= st_reg.trip_delay |=> o_trip)
    else $error("trip late after its delay");
  a_block_held: assert property (@(posedge i_clk) // R7
    disable iff (!rst_n) !tick |=> $stable(st_reg.blk_sampled))
    else $error("blocking sample changed mid cycle");

  // condition code
  a_normal_quiet: assert property (@(posedge i_clk) // R12
    disable iff (!rst_n) o_condition == COND_NORMAL |->
      !(o_alarm1 || o_alarm2 || o_inhibit || o_trip || o_blocked))
    else $error("output driven in normal condition");
  a_cond_order: assert property (@(posedge i_clk) // R20
    disable iff (!rst_n) o_trip && !o_blocked |-> o_condition == COND_TRIP)
    else $error("condition not most severe");
  a_cond_blocked: assert property (@(posedge i_clk) // R20
    disable iff (!rst_n) o_blocked |-> o_condition == COND_BLOCKED)
    else $error("blocked not reported first");
  a_cond_inhibit: assert property (@(posedge i_clk) // R20
    disable iff (!rst_n) o_inhibit && !o_trip && !o_blocked |->
      o_condition == COND_INHIBIT)
    else $error("inhibit not reported");
  a_cond_alarm2: assert property (@(posedge i_clk) // R20
    disable iff (!rst_n) o_alarm2 && !o_inhibit && !o_trip && !o_blocked |->
      o_condition == COND_ALARM2)
    else $error("alarm 2 not reported");

  // setting faults and substitutes
  a_sf_fault: assert property (@(posedge i_clk) // R14
    disable iff (!rst_n) i_settings.sf_invalid |=> o_faults[0] &&
      o_used.service_factor == FACTOR_ONE)
    else $error("service factor fault not handled");
  a_sf_clear: assert property (@(posedge i_clk) // R14
    disable iff (!rst_n) !i_settings.sf_invalid |=> !o_faults[0])
    else $error("service factor fault kept");
  a_amb_fault: assert property (@(posedge i_clk) // R15
    disable iff (!rst_n) i_settings.amb_invalid |=> o_faults[1] &&
      o_used.ambient_k == FACTOR_ONE)
    else $error("ambient fault not handled");
  a_nom_fault: assert property (@(posedge i_clk) // R16
    disable iff (!rst_n) i_settings.nom_invalid |=> o_faults[2] &&
      o_used.nominal_calc == FACTOR_ONE)
    else $error("nominal current fault not handled");
  a_ambk_flag: assert property (@(posedge i_clk) // R17
    disable iff (!rst_n) 1'b1 |=>
      o_faults[3] == $past(i_settings.ambk_inconsistent))
    else $error("ambient k flag wrong");

  // load class and live settings
  a_load_light: assert property (@(posedge i_clk) // R13
    disable iff (!rst_n) i_current < LIGHT_LOAD_LIMIT |=>
      o_load == LOAD_LIGHT)
    else $error("light load not reported");
  a_load_high: assert property (@(posedge i_clk) // R13
    disable iff (!rst_n) i_current >= HIGH_LOAD_LIMIT &&
      i_current > i_pickup_current |=> o_load == LOAD_HIGH)
    else $error("high overload not reported");
  a_trip_lvl_write: assert property (@(posedge i_clk) // R4 R6
    disable iff (!rst_n) i_wr && i_addr == ADDR_TRIP_LVL |=>
      {21'h0, st_reg.trip_lvl} == ($past(i_wdata) & 32'h0000_07ff))
    else $error("trip level write not taken");
  a_delay_write: assert property (@(posedge i_clk) // R5 R6
    disable iff (!rst_n) i_wr && i_addr == ADDR_TRIP_DELAY |=>
      {12'h0, st_reg.trip_delay} == ($past(i_wdata) & 32'h000f_ffff))
    else $error("trip delay write not taken");

endmodule : thermal_overload_stage
`default_nettype wire

// [blocking_matrix.sv]
// blocking matrix model that drives the stage's blocking input
`default_nettype none
module blocking_matrix (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_request,
  output logic o_block
);
  timeunit 1ns;
  timeprecision 1ns;
  // pass a block request on one clock later, long before any expiry
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_block <= 1'b0;
    end else begin
      o_block <= i_request;
    end
  end
endmodule : blocking_matrix
`default_nettype wire

// [testbench.sv]
// self-checking bench of the thermal overload output stage
`default_nettype none
module testbench;
  import thermal_overload_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned CYC = 8;
  logic clk, reset_n, wr, rd, block_req, block_line;
  logic a1, a2, inh, trip, start, blocked, cyc;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, rv;
  logic [10:0] cap;
  logic [15:0] cur, pick;
  logic [3:0] faults, outs;
  settings_s sets;
  cond_e cond;
  load_e load;
  factors_s used;
  int bad_count = 0;
  int cmp_count = 0;
  assign outs = {trip, inh, a2, a1};
  ////////////////////////////////////////////////////////////////////////
  // device under test and far side
  thermal_overload_stage #(.P_CYCLE_CLKS(CYC)) u_thermal_overload_stage (
    .i_clk(clk), .i_reset_n(reset_n), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_capacity(cap),
    .i_current(cur), .i_pickup_current(pick), .i_block(block_line),
    .i_settings(sets), .o_alarm1(a1), .o_alarm2(a2), .o_inhibit(inh),
    .o_trip(trip), .o_start(start), .o_blocked(blocked),
    .o_condition(cond), .o_load(load), .o_faults(faults), .o_used(used),
    .o_cycle(cyc));
  blocking_matrix u_blocking_matrix (.i_clk(clk), .i_reset_n(reset_n),
    .i_request(block_req), .o_block(block_line));
  ////////////////////////////////////////////////////////////////////////
  // shared helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string what);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t ns: %s", $time, what);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask : rd_reg
  // step to the first clock of the next processing cycle
  task automatic next_cycle();
    for (int n = 0; n < 2 * CYC; n++) begin
      @(negedge clk);
      if (cyc === 1'b1) break;
    end
  endtask : next_cycle
  task automatic drive_cap(input logic [10:0] c);
    @(posedge clk);
    cap <= c;
    next_cycle();
    next_cycle();
  endtask : drive_cap
  task automatic until_start(output int n);
    n = 0;
    while (start !== 1'b1 && n < 6) begin
      next_cycle();
      n++;
    end
  endtask : until_start
  ////////////////////////////////////////////////////////////////////////
  // reset values, unmapped read, disabled outputs stay quiet
  task automatic t_reset();
    logic [7:0] ra[7] = '{ADDR_ENABLE, ADDR_ALARM1_LVL, ADDR_ALARM2_LVL,
      ADDR_INHIBIT_LVL, ADDR_TRIP_LVL, ADDR_TRIP_DELAY, 8'h1c};
    logic [31:0] ex[7] = '{32'(ENABLE_RST), 32'(ALARM1_LVL_RST),
      32'(ALARM2_LVL_RST), 32'(INHIBIT_LVL_RST), 32'(TRIP_LVL_RST),
      32'(TRIP_DELAY_RST), 32'h0};
    for (int i = 0; i < 7; i++) begin
      rd_reg(ra[i], rv);
      chk(rv, ex[i], "register reset value");
    end
    drive_cap(11'h3e8);
    chk(outs, 4'h0, "disabled output driven");
    chk(start, 1'b0, "start without trip enable");
    chk(cond, COND_NORMAL, "condition not normal");
  endtask : t_reset
  // thresholds at their boundaries and condition priority
  task automatic t_levels();
    logic [10:0] cv[10] = '{11'h12b, 11'h12c, 11'h1f3, 11'h1f4, 11'h31f,
      11'h320, 11'h3e7, 11'h3e8, 11'h3e7, 11'h12b};
    logic [3:0] ov[10] = '{4'h0, 4'h1, 4'h1, 4'h3, 4'h3, 4'h7, 4'h7,
      4'hf, 4'h7, 4'h0};
    cond_e kv[10] = '{COND_NORMAL, COND_ALARM1, COND_ALARM1, COND_ALARM2,
      COND_ALARM2, COND_INHIBIT, COND_INHIBIT, COND_TRIP, COND_INHIBIT,
      COND_NORMAL};
    wr_reg(ADDR_ALARM1_LVL, 32'h12c);
    wr_reg(ADDR_ALARM2_LVL, 32'h1f4);
    wr_reg(ADDR_ENABLE, 32'hffff_ffff);
    rd_reg(ADDR_ENABLE, rv);
    chk(rv, 32'h0000_000f, "enable readback");
    for (int i = 0; i < 10; i++) begin
      drive_cap(cv[i]);
      chk(outs, ov[i], "outputs against thresholds");
      chk(cond, kv[i], "condition priority");
    end
  endtask : t_levels
  // start at pick-up, trip two cycles later
  task automatic t_delay();
    int n;
    wr_reg(ADDR_TRIP_DELAY, 32'h2);
    drive_cap(11'h3e7);
    @(posedge clk);
    cap <= 11'h3e8;
    until_start(n);
    chk(start, 1'b1, "no start on pick-up");
    chk(trip, 1'b0, "trip ahead of delay");
    n = 0;
    while (trip !== 1'b1 && n < 6) begin
      next_cycle();
      n++;
    end
    chk(n, 2, "trip delay in cycles");
  endtask : t_delay
  // blocking before and after start, short pulse between cycle starts
  task automatic t_block();
    int n;
    drive_cap(11'h3e7);
    @(posedge clk);
    block_req <= 1'b1;
    drive_cap(11'h3e8);
    chk(blocked, 1'b1, "no blocked indication");
    chk({start, trip}, 2'h0, "blocked pick-up processed");
    chk(cond, COND_BLOCKED, "condition not blocked");
    @(posedge clk);
    block_req <= 1'b0;
    until_start(n);
    chk(start, 1'b1, "no start after release");
    chk(trip, 1'b0, "trip at restart");
    @(posedge clk);
    block_req <= 1'b1;
    drive_cap(11'h3e8);
    chk({start, trip}, 2'h0, "start kept under blocking");
    @(posedge clk);
    block_req <= 1'b0;
    until_start(n);
    chk(start, 1'b1, "no start after block");
    chk(trip, 1'b0, "delay not restarted");
    next_cycle();
    chk(trip, 1'b0, "trip ahead of full delay");
    next_cycle();
    chk(trip, 1'b1, "no trip after full delay");
    wr_reg(ADDR_TRIP_DELAY, 32'h0);
    drive_cap(11'h3e8);
    next_cycle();
    @(posedge clk);
    block_req <= 1'b1;
    @(posedge clk);
    block_req <= 1'b0;
    next_cycle();
    chk({blocked, start, trip}, 3'h3, "mid-cycle block seen");
  endtask : t_block
  // status word while tripped under normal load
  task automatic t_status();
    logic [31:0] ex;
    ex = {17'h0, 4'h0, 2'(LOAD_NORMAL), 3'(COND_TRIP), 2'h1, 4'hf};
    rd_reg(ADDR_STATUS, rv);
    chk(rv, ex, "status word");
  endtask : t_status
  // load classes at their limits
  task automatic t_load();
    logic [15:0] cv[6] = '{16'h0009, 16'h000a, 16'h03e8, 16'h03e9,
      16'h07cf, 16'h07d0};
    load_e lv[6] = '{LOAD_LIGHT, LOAD_NORMAL, LOAD_NORMAL, LOAD_OVER,
      LOAD_OVER, LOAD_HIGH};
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      cur <= cv[i];
      repeat (3) @(negedge clk);
      chk(load, lv[i], "load class");
    end
  endtask : t_load
  // each setting fault alone, then none
  task automatic t_faults();
    logic [3:0] b;
    for (int i = 0; i < 5; i++) begin
      b = (i < 4) ? 4'(1 << i) : 4'h0;
      @(posedge clk);
      sets.sf_invalid <= b[0];
      sets.amb_invalid <= b[1];
      sets.nom_invalid <= b[2];
      sets.ambk_inconsistent <= b[3];
      repeat (3) @(negedge clk);
      chk(faults, b, "fault flags");
      chk(used.service_factor, b[0] ? FACTOR_ONE : 16'h0120, "sf");
      chk(used.ambient_k, b[1] ? FACTOR_ONE : 16'h00e0, "amb k");
      chk(used.nominal_calc, b[2] ? FACTOR_ONE : 16'h0110, "nom");
    end
  endtask : t_faults
  ////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic final_report();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report
  // clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // main sequence
  initial begin
    reset_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    cap = 11'h000;
    cur = 16'h01f4;
    pick = 16'h03e8;
    block_req = 1'b0;
    sets = '{16'h0120, 1'b0, 16'h00e0, 1'b0, 16'h0110, 1'b0, 1'b0};
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_levels();
    t_delay();
    t_block();
    t_status();
    t_load();
    t_faults();
    final_report();
  end
  // watchdog against a hang
  initial begin
    #1_000_000;
    bad_count++;
    final_report();
  end
endmodule : testbench
`default_nettype wire
